// >>> card_seq_pkg.sv
package card_seq_pkg;

    // Local clock and card clock derivation.
    localparam int CLK_HZ = 100_000_000;
    localparam int CARD_CLK_HZ = 5_000_000;
    localparam int CARD_HALF_CYC = CLK_HZ / (2 * CARD_CLK_HZ);
    localparam logic [3:0] CARD_HALF_LAST = 4'(CARD_HALF_CYC - 1);

    // Card-clock counts.
    localparam int RST_LOW_CLK = 400;
    localparam int ATR_MAX_CLK = 40_000;
    localparam int ETU_CLK = 372;
    localparam int WARM_GAP_CLK = 12 * ETU_CLK;
    localparam int CHAR_CLK = 10 * ETU_CLK;
    localparam logic [15:0] RST_LOW_TICKS = 16'(RST_LOW_CLK);
    localparam logic [15:0] CHAR_TICKS = 16'(CHAR_CLK);
    localparam logic [15:0] CYC_SAT = 16'hFFFF;

    // Class retry spacing, measured on the local clock.
    localparam int GUARD_TIME_US = 10_000;
    localparam int GUARD_CYC_DEF = GUARD_TIME_US * (CLK_HZ / 1_000_000);

    // Spacing between the steps of activation and deactivation.
    localparam logic [7:0] STEP_LAST = 8'h0F;

    typedef enum logic [13:0] {
        S_IDLE     = 14'h0001,
        S_ACT_RST  = 14'h0002,
        S_ACT_VCC  = 14'h0004,
        S_ACT_IO   = 14'h0008,
        S_COLD     = 14'h0010,
        S_WAIT_ATR = 14'h0020,
        S_ATR_RX   = 14'h0040,
        S_OPER     = 14'h0080,
        S_WARM     = 14'h0100,
        S_D_RST    = 14'h0200,
        S_D_CLK    = 14'h0400,
        S_D_IO     = 14'h0800,
        S_D_VCC    = 14'h1000,
        S_GUARD    = 14'h2000
    } seq_state_e;

    typedef enum logic [1:0] {
        CLASS_A = 2'h1,
        CLASS_B = 2'h2,
        CLASS_C = 2'h3
    } op_class_e;

    typedef enum logic [1:0] {
        MODE_NONE     = 2'h0,
        MODE_SPECIFIC = 2'h1,
        MODE_PPS      = 2'h2,
        MODE_FIRST    = 2'h3
    } proto_mode_e;

    typedef struct packed {
        logic vcc_en;
        logic rst;
        logic clk;
        logic io_o;
        logic io_oe;
    } card_pins_s;

    typedef struct packed {
        logic done;
        logic class_ind;
        logic class_match;
        logic spec_mode;
        logic pps_start;
        logic pps_ok;
        logic card_fail;
        logic spec_fault;
    } atr_info_s;

    typedef struct packed {
        logic active;
        logic atr_seen;
        logic warm_ok;
        logic timeout;
        logic aborted;
        logic defaults;
        proto_mode_e mode;
        op_class_e cls;
    } seq_status_s;

endpackage

// >>> card_seq.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01 - Activate in order: reset low, power on, I/O receive, then clock.
// RULE_02 - Ignore the I/O line while activation is running.
// RULE_03 - Card drives I/O high within 200 clocks of the clock starting.
// RULE_04 - Cold reset holds reset low at least 400 card clocks after clock start.
// RULE_05 - Ignore I/O whenever reset is held low, cold or warm.
// RULE_06 - Card answers between 400 and 40000 clocks after reset rises.
// RULE_07 - No answer within 40000 clocks with reset high forces deactivation.
// RULE_08 - Warm reset only after two characters and 4464 clocks past the second.
// RULE_09 - Warm reset holds reset low 400 clocks with power and clock kept.
// RULE_10 - Card drives I/O high within 200 clocks of warm reset falling.
// RULE_11 - Matching class indicator continues, or deactivate, wait 10 ms, new class.
// RULE_12 - No indicator keeps class; failing card deactivates, may retry after 10 ms.
// RULE_13 - No answer deactivates, then retries another class after 10 ms or aborts.
// RULE_14 - Class is fixed in operation; change needs deactivation and 10 ms.
// RULE_15 - Second TA present selects the announced specific protocol at once.
// RULE_16 - PPS request keeps defaults until success, then negotiated values apply.
// RULE_17 - Without PPS the first offered protocol starts with defaults.
// RULE_18 - Clock may stop only when idle and the card supports it.
// RULE_19 - The full activation and reset sequence can be repeated.
// RULE_20 - After specific mode, withhold warm reset until a fault is seen.
// RULE_21 - Deactivate in order: reset low, clock low, I/O low, power off.
// RULE_22 - During the answer one character unit is 372 card clocks.
// RULE_23 - The 10 ms class spacing is timed on the local clock.
module card_seq
    import card_seq_pkg::*;
#(
    parameter int GUARD_CYC = card_seq_pkg::GUARD_CYC_DEF,
    parameter int ATR_MAX_TICKS = card_seq_pkg::ATR_MAX_CLK,
    parameter int WARM_GAP_TICKS = card_seq_pkg::WARM_GAP_CLK
)
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Card contacts
    input wire logic card_io_in,
    input wire logic card_inserted,
    output card_seq_pkg::card_pins_s pins,
    // Session control
    input wire logic activate,
    input wire card_seq_pkg::op_class_e class_init,
    input wire card_seq_pkg::op_class_e class_next,
    input wire logic retry_class,
    input wire logic class_change,
    input wire logic warm_req,
    input wire logic deact_req,
    input wire logic clk_stop_req,
    input wire logic clk_stop_ok,
    input wire logic clk_stop_high,
    input wire card_seq_pkg::atr_info_s atr_info,
    // Status
    output card_seq_pkg::seq_status_s status
);
    import card_seq_pkg::*;

    logic rst_s1_r;
    logic rst_n_s;
    logic io_s1_r;
    logic io_s2_r;
    logic io_s3_r;
    logic ins_s1_r;
    logic ins_s2_r;
    seq_state_e state_r;
    seq_state_e state_nxt;
    logic [7:0] gap_cnt_r;
    logic [15:0] cyc_cnt_r;
    logic [19:0] guard_cnt_r;
    logic [3:0] div_cnt_r;
    logic vcc_r;
    logic rst_pin_r;
    logic cclk_r;
    logic io_oe_r;
    logic clk_run_r;
    logic t0_seen_r;
    logic retry_r;
    logic aborted_r;
    logic timeout_r;
    logic atr_seen_r;
    logic warm_ok_r;
    logic defaults_r;
    proto_mode_e mode_r;
    op_class_e class_r;
    op_class_e class_next_r;
    logic st_chg;
    logic gap_done;
    logic div_wrap;
    logic tick;
    logic stop_hold;
    logic io_fall;
    logic atr_late;
    logic warm_allow;
    logic go_deact;

    function automatic logic is_active(input seq_state_e s);
        is_active = (s != S_IDLE) && (s != S_GUARD) && (s != S_D_RST) &&
                    (s != S_D_CLK) && (s != S_D_IO) && (s != S_D_VCC);
    endfunction

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_r <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_s <= rst_s1_r;
        end
    end

    // Card contacts are asynchronous to clk.
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            io_s1_r <= 1'b1;
            io_s2_r <= 1'b1;
            io_s3_r <= 1'b1;
            ins_s1_r <= 1'b0;
            ins_s2_r <= 1'b0;
        end
        else if (ce)
        begin
            io_s1_r <= card_io_in;
            io_s2_r <= io_s1_r;
            io_s3_r <= io_s2_r;
            ins_s1_r <= card_inserted;
            ins_s2_r <= ins_s1_r;
        end
    end

    assign st_chg = (state_nxt != state_r);
    assign gap_done = (gap_cnt_r == STEP_LAST);
    assign div_wrap = (div_cnt_r == CARD_HALF_LAST);
    assign stop_hold = (state_r == S_OPER) && clk_stop_req && clk_stop_ok &&
                       (cclk_r == clk_stop_high); // RULE_18
    assign tick = clk_run_r && !stop_hold && div_wrap && !cclk_r;
    // Edges on I/O are looked at only once reset is high.
    assign io_fall = io_s3_r && !io_s2_r &&
                     ((state_r == S_WAIT_ATR) || (state_r == S_ATR_RX)); // RULE_02 RULE_05
    assign atr_late = (cyc_cnt_r >= 16'(ATR_MAX_TICKS));
    assign warm_allow = warm_ok_r && warm_req;
    assign go_deact = deact_req || !ins_s2_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (ins_s2_r && activate)
                    state_nxt = S_ACT_RST;
            S_ACT_RST:
                if (gap_done)
                    state_nxt = S_ACT_VCC; // RULE_01
            S_ACT_VCC:
                if (gap_done)
                    state_nxt = S_ACT_IO;
            S_ACT_IO:
                if (gap_done)
                    state_nxt = S_COLD;
            S_COLD:
                if (cyc_cnt_r >= RST_LOW_TICKS)
                    state_nxt = S_WAIT_ATR; // RULE_04
            S_WAIT_ATR:
                if (io_fall)
                    state_nxt = S_ATR_RX;
                else if (atr_late)
                    state_nxt = S_D_RST; // RULE_07 RULE_13
            S_ATR_RX:
                if (warm_allow)
                    state_nxt = S_WARM; // RULE_08
                else if (atr_info.done)
                    state_nxt = S_OPER;
            S_OPER:
                if (warm_allow)
                    state_nxt = S_WARM;
                else if (atr_info.card_fail || class_change)
                    state_nxt = S_D_RST; // RULE_11 RULE_12 RULE_14
            S_WARM:
                if (cyc_cnt_r >= RST_LOW_TICKS)
                    state_nxt = S_WAIT_ATR; // RULE_09
            S_D_RST:
                if (gap_done)
                    state_nxt = S_D_CLK; // RULE_21
            S_D_CLK:
                if (gap_done)
                    state_nxt = S_D_IO;
            S_D_IO:
                if (gap_done)
                    state_nxt = S_D_VCC;
            S_D_VCC:
                if (gap_done)
                    state_nxt = retry_r ? S_GUARD : S_IDLE;
            S_GUARD:
                if (guard_cnt_r >= 20'(GUARD_CYC))
                    state_nxt = S_ACT_RST; // RULE_23
            default:
                state_nxt = S_IDLE;
        endcase
        if (is_active(state_r) && go_deact)
            state_nxt = S_D_RST;
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            state_r <= S_IDLE;
        else if (ce)
            state_r <= state_nxt; // RULE_19
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            gap_cnt_r <= 8'h00;
            guard_cnt_r <= 20'h00000;
        end
        else if (ce)
        begin
            gap_cnt_r <= (st_chg || gap_done) ? 8'h00 : gap_cnt_r + 8'h01;
            if (state_r != S_GUARD)
                guard_cnt_r <= 20'h00000;
            else if (guard_cnt_r != 20'hFFFFF)
                guard_cnt_r <= guard_cnt_r + 20'h00001;
        end
    end

    // Card clock divider; a stop only freezes it at the requested level.
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            div_cnt_r <= 4'h0;
            cclk_r <= 1'b0;
            clk_run_r <= 1'b0;
        end
        else if (ce)
        begin
            if (state_nxt == S_COLD && state_r == S_ACT_IO)
                clk_run_r <= 1'b1; // RULE_01
            else if (state_r == S_D_CLK)
                clk_run_r <= 1'b0;
            if (state_r == S_D_CLK || !clk_run_r)
            begin
                cclk_r <= 1'b0; // RULE_21
                div_cnt_r <= 4'h0;
            end
            else if (!stop_hold)
            begin
                div_cnt_r <= div_wrap ? 4'h0 : div_cnt_r + 4'h1;
                if (div_wrap)
                    cclk_r <= !cclk_r;
            end
        end
    end

    // Card-clock counter; at the second character's start bit it restarts to time the warm gap.
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            cyc_cnt_r <= 16'h0000;
            t0_seen_r <= 1'b0;
        end
        else if (ce)
        begin
            if (st_chg && (state_nxt == S_COLD || state_nxt == S_WARM ||
                           state_nxt == S_WAIT_ATR || state_r == S_WAIT_ATR))
            begin
                cyc_cnt_r <= 16'h0000;
                t0_seen_r <= 1'b0;
            end
            else if (state_r == S_ATR_RX && !t0_seen_r && io_fall &&
                     cyc_cnt_r >= CHAR_TICKS)
            begin
                cyc_cnt_r <= 16'h0000; // RULE_22
                t0_seen_r <= 1'b1;
            end
            else if (tick && cyc_cnt_r != CYC_SAT)
                cyc_cnt_r <= cyc_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            vcc_r <= 1'b0;
            rst_pin_r <= 1'b0;
            io_oe_r <= 1'b0;
        end
        else if (ce)
        begin
            case (state_nxt)
                S_ACT_VCC:
                    vcc_r <= 1'b1; // RULE_01
                S_ACT_IO:
                    io_oe_r <= 1'b0;
                S_WAIT_ATR:
                    rst_pin_r <= 1'b1;
                S_WARM, S_D_RST:
                    rst_pin_r <= 1'b0; // RULE_09 RULE_21
                S_D_IO:
                    io_oe_r <= 1'b1;
                S_IDLE, S_GUARD:
                    if (state_r == S_D_VCC)
                        io_oe_r <= 1'b0;
                default:
                    rst_pin_r <= rst_pin_r;
            endcase
            if (state_nxt == S_D_VCC && state_r == S_D_IO)
                vcc_r <= 1'b0;
        end
    end

    // Retry choice is fixed when deactivation begins.
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            retry_r <= 1'b0;
            aborted_r <= 1'b0;
            timeout_r <= 1'b0;
            class_r <= CLASS_A;
            class_next_r <= CLASS_A;
        end
        else if (ce)
        begin
            timeout_r <= 1'b0;
            if (state_nxt == S_D_RST && state_r != S_D_RST)
            begin
                retry_r <= !go_deact && (class_change || retry_class); // RULE_11 RULE_12
                class_next_r <= class_next;
                if (state_r == S_WAIT_ATR && !go_deact)
                begin
                    timeout_r <= 1'b1;
                    aborted_r <= !retry_class; // RULE_13
                end
            end
            if (state_r == S_IDLE && state_nxt == S_ACT_RST)
            begin
                class_r <= class_init;
                aborted_r <= 1'b0;
            end
            else if (state_r == S_GUARD && state_nxt == S_ACT_RST)
                class_r <= class_next_r; // RULE_14
        end
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            atr_seen_r <= 1'b0;
            warm_ok_r <= 1'b0;
            mode_r <= MODE_NONE;
            defaults_r <= 1'b1;
        end
        else if (ce)
        begin
            atr_seen_r <= (state_r == S_ATR_RX) || (state_r == S_OPER);
            warm_ok_r <= t0_seen_r && (cyc_cnt_r >= 16'(WARM_GAP_TICKS)) &&
                         ((state_r == S_ATR_RX) || (state_r == S_OPER)) &&
                         !(atr_info.spec_mode && !atr_info.spec_fault) &&
                         !warm_allow; // RULE_08 RULE_20
            if (state_r == S_ATR_RX && state_nxt == S_OPER)
            begin
                if (atr_info.spec_mode)
                begin
                    mode_r <= MODE_SPECIFIC; // RULE_15
                    defaults_r <= 1'b0;
                end
                else
                begin
                    mode_r <= atr_info.pps_start ? MODE_PPS : MODE_FIRST; // RULE_17
                    defaults_r <= 1'b1;
                end
            end
            else if (state_r == S_OPER && mode_r == MODE_PPS && atr_info.pps_ok)
                defaults_r <= 1'b0; // RULE_16
            else if (!is_active(state_r))
            begin
                mode_r <= MODE_NONE;
                defaults_r <= 1'b1;
            end
        end
    end

    assign pins = '{vcc_en: vcc_r, rst: rst_pin_r, clk: cclk_r,
                    io_o: 1'b0, io_oe: io_oe_r};
    assign status = '{active: vcc_r, atr_seen: atr_seen_r, warm_ok: warm_ok_r,
                      timeout: timeout_r, aborted: aborted_r, defaults: defaults_r,
                      mode: mode_r, cls: class_r};

    sequence s_powered_reset_low;
        vcc_r && !rst_pin_r;
    endsequence

    sequence s_line_parked;
        !rst_pin_r && !cclk_r && io_oe_r;
    endsequence

    property p_power_after_rst;
        @(posedge clk) disable iff (!rst_n_s)
        $rose(vcc_r) |-> !rst_pin_r && !clk_run_r && !io_oe_r;
    endproperty
    a_power_after_rst: assert property (p_power_after_rst) // RULE_01
        else $error("Power rose with reset high, clock running or I/O driven.");

    property p_clock_last;
        @(posedge clk) disable iff (!rst_n_s)
        $rose(clk_run_r) |-> s_powered_reset_low and !io_oe_r;
    endproperty
    a_clock_last: assert property (p_clock_last) // RULE_01
        else $error("Card clock started before power and I/O release.");

    property p_cold_hold;
        @(posedge clk) disable iff (!rst_n_s)
        $rose(rst_pin_r) |-> $past(cyc_cnt_r) >= RST_LOW_TICKS;
    endproperty
    a_cold_hold: assert property (p_cold_hold) // RULE_04
        else $error("Reset released before 400 card clocks.");

    property p_io_ignored;
        @(posedge clk) disable iff (!rst_n_s)
        !rst_pin_r |-> !io_fall;
    endproperty
    a_io_ignored: assert property (p_io_ignored) // RULE_05
        else $error("I/O edge used while reset low.");

    property p_atr_timeout;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && state_r == S_WAIT_ATR && atr_late && !io_fall) |=>
            state_r == S_D_RST ##1 !rst_pin_r;
    endproperty
    a_atr_timeout: assert property (p_atr_timeout) // RULE_07
        else $error("Missing answer did not start deactivation.");

    property p_warm_gap;
        @(posedge clk) disable iff (!rst_n_s)
        (ce && state_r != S_WARM && state_nxt == S_WARM) |->
            t0_seen_r && cyc_cnt_r >= 16'(WARM_GAP_TICKS);
    endproperty
    a_warm_gap: assert property (p_warm_gap) // RULE_08
        else $error("Warm reset issued too early.");

    property p_warm_keep;
        @(posedge clk) disable iff (!rst_n_s)
        state_r == S_WARM |-> s_powered_reset_low and clk_run_r;
    endproperty
    a_warm_keep: assert property (p_warm_keep) // RULE_09
        else $error("Power or clock lost during warm reset.");

    property p_deact_order;
        @(posedge clk) disable iff (!rst_n_s)
        $fell(vcc_r) |-> s_line_parked ##1 !vcc_r;
    endproperty
    a_deact_order: assert property (p_deact_order) // RULE_21
        else $error("Power removed before reset, clock and I/O were low.");

    property p_class_fixed;
        @(posedge clk) disable iff (!rst_n_s)
        (state_r == S_OPER) ##1 (state_r == S_OPER) |-> $stable(class_r);
    endproperty
    a_class_fixed: assert property (p_class_fixed) // RULE_14
        else $error("Class changed during operation.");

    property p_guard_wait;
        @(posedge clk) disable iff (!rst_n_s)
        (state_r == S_GUARD && state_nxt == S_ACT_RST) |->
            guard_cnt_r >= 20'(GUARD_CYC);
    endproperty
    a_guard_wait: assert property (p_guard_wait) // RULE_23
        else $error("New class applied before the 10 ms spacing.");

endmodule

// >>> card_model.sv
`timescale 1ns/10ps
module card_model
(
    // Contacts driven by the interface
    input wire card_seq_pkg::card_pins_s pins,
    // Answer control
    input wire logic answer_en,
    input wire logic [15:0] ans_delay,
    // Resolved I/O line
    output wire logic io
);
    import card_seq_pkg::*;

    localparam logic [9:0] TS_PAT = 10'h181;
    localparam logic [9:0] T0_PAT = 10'h1FF;
    logic [15:0] cnt;
    logic rst_q;
    logic card_o;
    int t;
    int m;

    // Counts card clocks since the last RST edge; losing power clears the card.
    always @(posedge pins.clk or negedge pins.vcc_en)
    begin
        if (!pins.vcc_en)
        begin
            cnt <= 16'h0000;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_q <= pins.rst;
            cnt <= (pins.rst != rst_q) ? 16'h0000 : cnt + 16'h0001;
        end
    end

    // The card holds I/O low for a while after reset falls, so a host that
    // listens too early sees a false start bit.
    always_comb
    begin
        t = int'(cnt) - int'(ans_delay);
        m = t / ETU_CLK;
        if (!pins.rst)
            card_o = (cnt >= 16'h0064);
        else if (!answer_en || t < 0)
            card_o = 1'b1;
        else if (m < 10)
            card_o = TS_PAT[9 - m];
        else if (m >= 12 && m < 22)
            card_o = T0_PAT[21 - m];
        else
            card_o = 1'b1;
    end

    // Unpowered, the pull-up has no supply and the line sits low.
    assign io = pins.vcc_en & ~(pins.io_oe & ~pins.io_o) & card_o;
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    import card_seq_pkg::*;

    localparam int GUARD = 200;
    localparam int ATR_MAX = 500;
    localparam int WARM_GAP = 100;
    logic clk;
    logic resetn;
    logic card_inserted;
    logic activate;
    op_class_e class_init;
    op_class_e class_next;
    op_class_e c;
    logic retry_class;
    logic class_change;
    logic warm_req;
    logic deact_req;
    atr_info_s atr_info;
    card_pins_s pins;
    seq_status_s status;
    wire io;
    logic answer_en;
    logic [15:0] ans_delay;
    logic [31:0] seed;
    int n_fail;
    int compares;
    int n_off;
    int i;
    logic cq, rq, vq, oq, wq;
    logic guard_chk;
    logic clk_stop;
    logic [15:0] held;
    logic [15:0] low_cc;
    logic [15:0] hi_cc;
    logic [15:0] off_cyc;
    wire cc_edge = pins.clk & ~cq;

    card_seq #(.GUARD_CYC(GUARD), .ATR_MAX_TICKS(ATR_MAX), .WARM_GAP_TICKS(WARM_GAP)) card_seq_i (
        .clk(clk), .resetn(resetn), .ce(1'b1), .card_io_in(io), .card_inserted(card_inserted),
        .pins(pins), .activate(activate), .class_init(class_init), .class_next(class_next),
        .retry_class(retry_class), .class_change(class_change), .warm_req(warm_req),
        .deact_req(deact_req), .clk_stop_req(clk_stop), .clk_stop_ok(clk_stop),
        .clk_stop_high(1'b0),
        .atr_info(atr_info), .status(status));
    card_model card_model_i (.pins(pins), .answer_en(answer_en), .ans_delay(ans_delay), .io(io));

    task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_ge(input logic [15:0] got, input logic [15:0] lo, input string msg);
        compares++;
        if ((got >= lo) !== 1'b1)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %0d below %0d", $time, msg, got, lo);
        end
    endtask

    task automatic summarize();
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic pick(input logic [2:0] sel);
        case (sel)
            3'h0: return pins.vcc_en;
            3'h1: return pins.rst;
            3'h2: return status.warm_ok;
            3'h3: return status.timeout;
            default: return pins.rst & pins.vcc_en & ~io;
        endcase
    endfunction

    // Expected {defaults, mode} once the answer is complete.
    function automatic logic [15:0] exp_mode(input int k);
        return (k == 0) ? 16'({1'b0, MODE_SPECIFIC}) : 16'({1'b1, MODE_FIRST});
    endfunction

    task automatic wait_on(input logic [2:0] sel, input logic v);
        int k;
        for (k = 0; k < 200000; k++)
        begin
            @(posedge clk);
            if (pick(sel) === v)
                break;
        end
        chk_eq(16'(k < 200000), 16'h0001, "wait bound");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cq <= pins.clk;
        rq <= pins.rst;
        vq <= pins.vcc_en;
        oq <= pins.io_oe;
        wq <= status.warm_ok;
        low_cc <= (pins.rst || !pins.vcc_en) ? 16'h0000 : low_cc + 16'(cc_edge);
        hi_cc <= pins.rst ? hi_cc + 16'(cc_edge) : 16'h0000;
        off_cyc <= pins.vcc_en ? 16'h0000 : off_cyc + 16'h0001;
        if (pins.rst && !rq)
        begin
            chk_ge(low_cc, 16'(RST_LOW_CLK), "rst low span");
            chk_eq(16'(status.atr_seen), 16'h0000, "io ignored");
        end
        if (cc_edge && !pins.rst && low_cc == 16'h0000)
            chk_eq(16'({pins.vcc_en, pins.io_oe}), 16'h0002, "clock start order");
        if (pins.vcc_en && !vq)
        begin
            chk_eq(16'({pins.rst, pins.clk}), 16'h0000, "power order");
            if (guard_chk)
                chk_ge(off_cyc, 16'(GUARD), "class spacing");
        end
        if (!pins.vcc_en && vq)
        begin
            n_off <= n_off + 1;
            chk_eq(16'({pins.rst, pins.clk, pins.io_oe}), 16'h0001, "off order");
        end
        if (pins.io_oe && !oq && pins.vcc_en)
            chk_eq(16'({pins.rst, pins.clk}), 16'h0000, "io low order");
        if (status.warm_ok && !wq)
            chk_ge(hi_cc, ans_delay + 16'(4464 + WARM_GAP), "warm spacing");
        if (status.timeout)
            chk_ge(hi_cc, 16'(ATR_MAX), "answer timeout");
    end

    initial
    begin
        seed = 32'hE2E8;
        {resetn, card_inserted, activate, retry_class, class_change} = 5'h00;
        {warm_req, deact_req, answer_en, guard_chk, clk_stop} = 5'h00;
        n_fail = 0;
        compares = 0;
        n_off = 0;
        class_init = CLASS_B;
        class_next = CLASS_C;
        atr_info = '0;
        ans_delay = 16'h0190;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cyc(3);
        chk_eq(16'(pins), 16'h0000, "pins after reset");
        chk_eq(16'({status.active, status.defaults, status.cls}), 16'h0005, "status after reset");
        card_inserted <= 1'b1;
        retry_class <= 1'b1;
        activate <= 1'b1;
        wait_on(3'h0, 1'b1);
        activate <= 1'b0;
        cyc(2);
        chk_eq(16'(status.cls), 16'(CLASS_B), "first class");
        wait_on(3'h3, 1'b1);
        guard_chk <= 1'b1;
        answer_en <= 1'b1;
        ans_delay <= 16'h0190 + 16'($unsigned($random(seed)) % 51);
        wait_on(3'h0, 1'b0);
        wait_on(3'h0, 1'b1);
        cyc(2);
        chk_eq(16'(status.cls), 16'(CLASS_C), "retry class");
        wait_on(3'h4, 1'b1);
        cyc(4);
        chk_eq(16'(status.warm_ok), 16'h0000, "warm before T0");
        wait_on(3'h2, 1'b1);
        warm_req <= 1'b1;
        wait_on(3'h1, 1'b0);
        warm_req <= 1'b0;
        ans_delay <= 16'h0190 + 16'($unsigned($random(seed)) % 51);
        wait_on(3'h1, 1'b1);
        chk_eq(16'(n_off), 16'h0001, "power kept");
        wait_on(3'h4, 1'b1);
        cyc(4);
        atr_info <= '{done: 1'b1, pps_start: 1'b1, default: 1'b0};
        cyc(4);
        chk_eq(16'(status.defaults), 16'h0001, "defaults in pps");
        atr_info.pps_ok <= 1'b1;
        cyc(4);
        chk_eq(16'({status.defaults, status.mode}), 16'({1'b0, MODE_PPS}), "pps");
        clk_stop <= 1'b1;
        cyc(20);
        held = hi_cc;
        cyc(40);
        chk_eq(hi_cc, held, "clock held");
        clk_stop <= 1'b0;
        for (i = 0; i < 2; i++)
        begin
            c = (i == 0) ? CLASS_A : op_class_e'(2'h1 + 2'($unsigned($random(seed)) % 3));
            class_next <= c;
            class_change <= 1'b1;
            wait_on(3'h0, 1'b0);
            class_change <= 1'b0;
            atr_info <= '0;
            wait_on(3'h0, 1'b1);
            cyc(2);
            chk_eq(16'(status.cls), 16'(c), "changed class");
            wait_on(3'h4, 1'b1);
            cyc(4);
            atr_info <= '{done: 1'b1, spec_mode: (i == 0), default: 1'b0};
            cyc(4);
            chk_eq(16'({status.defaults, status.mode}), exp_mode(i), "mode");
        end
        deact_req <= 1'b1;
        wait_on(3'h0, 1'b0);
        deact_req <= 1'b0;
        answer_en <= 1'b0;
        retry_class <= 1'b0;
        cyc(300);
        chk_eq(16'(status.active), 16'h0000, "no retry after stop");
        activate <= 1'b1;
        wait_on(3'h0, 1'b1);
        activate <= 1'b0;
        cyc(2);
        chk_eq(16'(status.cls), 16'(CLASS_B), "repeat session");
        wait_on(3'h3, 1'b1);
        chk_eq(16'(status.aborted), 16'h0001, "abort");
        summarize();
    end

    initial
    begin
        repeat (400000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule
